// [verification/dpm_pad_partner.sv]
// Model of the circuits wired to the upper digital pads and the reset pin.
`timescale 1ns/1ps
module dpm_pad_partner (
  input wire logic clk_i,
  input wire logic [10:0] pad_o_i,
  input wire logic [10:0] pad_oe_i,
  input wire logic [10:0] pad_pu_i,
  input wire logic [10:0] ext_en_i,
  input wire logic [10:0] ext_val_i,
  output logic [10:0] pad_i_o,
  input wire logic rst_oe_i,
  input wire logic ext_pull_i,
  output logic pin_o
);
  // A floating line without pull-up shows a pattern that flips every cycle.
  logic [10:0] float_r = 11'h555;
  always_ff @(posedge clk_i) begin
    float_r <= ~float_r;
  end
  // wire level: the device driver wins, then the outside, then the pull-up.
  always_comb begin
    for (int i = 0; i < 11; i++) begin
      pad_i_o[i] = pad_oe_i[i] ? pad_o_i[i] : ext_en_i[i] ? ext_val_i[i] :
                   pad_pu_i[i] ? 1'b1 : float_r[i];
    end
  end
  // pin pulled up, low when either party pulls it.
  assign pin_o = ~(rst_oe_i | ext_pull_i);
endmodule // dpm_pad_partner

// [verification/tb_digital_io_pin_mux.sv]
// Self-checking bench of the upper digital line pin multiplexer.
`timescale 1ns/1ps
module tb_digital_io_pin_mux;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, sleep = 1'b0, wake, irq;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, rdat;
  logic [10:0] pad_in, pad_out, pad_oe, pad_pu, ext_en = 11'h000, ext_val = 11'h000;
  logic [10:0] o, d, p, v;
  logic pin, pin_o, pin_oe, int_req = 1'b0, ext_pull = 1'b0, ext_rst;
  dpm_pkg::dpm_from_periph_s per = '0;
  dpm_pkg::dpm_to_periph_s to_per;
  int err_total = 0, n_tests = 0, k;
  // Alternate output table: enable mask and line index.
  localparam int PM[10] = '{1, 2, 8, 32, 64, 64, 128, 128, 512, 1024};
  localparam int LN[10] = '{0, 0, 1, 3, 2, 3, 2, 8, 5, 9};
  // Clock of 5 ns period.
  always #2.5 clk_i = ~clk_i;
  dpm_pin_mux i_dpm_pin_mux (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .pad_i(pad_in), .pad_o(pad_out), .pad_oe_o(pad_oe), .pad_pu_o(pad_pu),
    .periph_i(per), .periph_o(to_per), .sleep_i(sleep), .wake_o(wake), .irq_o(irq),
    .reset_pin_low_i(pin), .reset_pin_low_o(pin_o), .reset_pin_low_oe_o(pin_oe),
    .int_reset_req_i(int_req), .ext_reset_o(ext_rst));
  dpm_pad_partner i_dpm_pad_partner (.clk_i(clk_i), .pad_o_i(pad_out), .pad_oe_i(pad_oe),
    .pad_pu_i(pad_pu), .ext_en_i(ext_en), .ext_val_i(ext_val), .pad_i_o(pad_in),
    .rst_oe_i(pin_oe), .ext_pull_i(ext_pull), .pin_o(pin));
  // Prints the counts and the verdict, then stops.
  task conclude;
    $display("mismatches %0d comparisons %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Compares one value and counts the outcome.
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Lets n edges pass and settles after the last one.
  task tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // One classic Wishbone cycle, held until ack is sampled high.
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= wd;
    // Waits for ack however long it takes; only the watchdog ends a hang.
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] q;
    bus(1'b1, a, wd, q);
  endtask
  task rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask
  // Expected peripheral level for each row of the output table.
  function automatic logic fout(int i, dpm_pkg::dpm_from_periph_s s);
    case (i)
      0: return s.timer0_pwm_out;
      1: return s.slow_crystal_out;
      2: return s.timer2_pwm_out;
      3: return s.timer1_pwm_out;
      4: return s.antenna_diversity_out;
      5: return s.antenna_diversity_enable;
      6: return s.audio_word_select;
      7: return s.audio_serial_out;
      8: return s.periph_port_data_out;
      default: return s.uart_b_transmit;
    endcase
  endfunction
  // Cuts a hung run short.
  initial begin
    #60000;
    err_total++;
    conclude();
  end
  // Main sequence.
  initial begin
    void'($urandom(35138));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    tick(1);
    chk("oe", 11'h000, pad_oe);
    chk("pu", dpm_pkg::RST_PULL, pad_pu);
    chk("idle", dpm_pkg::TO_IDLE, to_per);
    rd("pull", dpm_pkg::OFS_PULL, 32'(dpm_pkg::RST_PULL));
    rd("unmapped", 8'h40, 32'h0);
    // Random general purpose traffic in both directions.
    for (int i = 0; i < 6; i++) begin
      o = 11'($urandom);
      d = 11'($urandom);
      p = 11'($urandom);
      v = 11'($urandom);
      wr(dpm_pkg::OFS_OUT, 32'(o));
      wr(dpm_pkg::OFS_DIR, 32'(d));
      wr(dpm_pkg::OFS_PULL, 32'(p));
      ext_en <= ~d;
      ext_val <= v;
      tick(6);
      chk("pad_o", o & d, pad_out & d);
      chk("pad_oe", d, pad_oe);
      chk("pad_pu", p, pad_pu);
      rd("in", dpm_pkg::OFS_IN, 32'((o & d) | (v & ~d)));
    end
    wr(dpm_pkg::OFS_DIR, 32'h0);
    ext_en <= 11'h7FF;
    // Each alternate output takes its line whatever the direction register says.
    for (int i = 0; i < 10; i++) begin
      per <= dpm_pkg::dpm_from_periph_s'($urandom);
      wr(dpm_pkg::OFS_PEN, 32'(PM[i]));
      tick(2);
      chk("alt_oe", 1'b1, pad_oe[LN[i]]);
      chk("alt_o", fout(i, per), pad_out[LN[i]]);
    end
    // With both enabled the debug port wins line 19; the uart level differs on purpose.
    wr(dpm_pkg::OFS_PEN, 32'hC00);
    per.uart_b_transmit <= per.jtag_tdo;
    per.jtag_tdo <= ~per.jtag_tdo;
    tick(2);
    chk("jtag_tdo", per.jtag_tdo, pad_out[9]);
    // Pad inputs reach their owners; an unowned input reads idle.
    v = 11'($urandom);
    ext_val <= v;
    wr(dpm_pkg::OFS_PEN, (1 << dpm_pkg::PE_PPORT) | (1 << dpm_pkg::PE_JTAG));
    tick(6);
    chk("pp_clk", v[4], to_per.periph_port_clock_in);
    chk("pp_di", v[6], to_per.periph_port_data_in);
    chk("tck", v[7], to_per.jtag_tck);
    chk("tdi", v[10], to_per.jtag_tdi);
    chk("rx_idle", 1'b1, to_per.uart_b_receive);
    // Timer inputs, audio in, two-wire and second uart together.
    per <= dpm_pkg::dpm_from_periph_s'($urandom);
    wr(dpm_pkg::OFS_PEN, 32'h594);
    tick(6);
    chk("t1_gate", v[1], to_per.timer1_clock_gate_in);
    chk("t1_cap", v[2], to_per.timer1_capture_in);
    chk("aud_in", v[3], to_per.audio_serial_in);
    chk("cts", v[7], to_per.uart_b_clear_to_send);
    chk("rx", v[10], to_per.uart_b_receive);
    chk("rts", per.uart_b_request_to_send, pad_out[8]);
    chk("tw_oe", {per.two_wire_data_oe, per.two_wire_clock_oe}, pad_oe[5:4]);
    chk("tw_o", 2'b00, pad_out[5:4]);
    chk("tw_clk", per.two_wire_clock_oe ? 1'b0 : v[4], to_per.two_wire_clock);
    chk("tw_dat", per.two_wire_data_oe ? 1'b0 : v[5], to_per.two_wire_data);
    // Peripheral port select and interrupt, then the audio bit clock alone.
    wr(dpm_pkg::OFS_PEN, 32'h280);
    tick(6);
    chk("sel_in", v[7], to_per.periph_port_select_in);
    chk("pp_irq", per.periph_port_irq_out, pad_out[8]);
    wr(dpm_pkg::OFS_PEN, 32'h080);
    tick(2);
    chk("bit_clk", per.audio_bit_clock, pad_out[7]);
    chk("bit_clk_oe", 1'b1, pad_oe[7]);
    wr(dpm_pkg::OFS_PEN, 32'h0);
    // Input event sets status, raises the interrupt, then mask and clear.
    k = $urandom_range(10, 0);
    wr(dpm_pkg::OFS_IEN, 1 << k);
    wr(dpm_pkg::OFS_MASK, 1 << k);
    v[k] = ~v[k];
    ext_val <= v;
    tick(8);
    rd("stat", dpm_pkg::OFS_STAT, 1 << k);
    tick(1);
    chk("irq", 1'b1, irq);
    wr(dpm_pkg::OFS_MASK, 32'h0);
    tick(2);
    chk("irq_masked", 1'b0, irq);
    wr(dpm_pkg::OFS_STAT, 1 << k);
    rd("stat_clr", dpm_pkg::OFS_STAT, 32'h0);
    // Sleep freezes the pads; an input event wakes the device.
    o = 11'($urandom);
    d = ~(11'h001 << k);
    wr(dpm_pkg::OFS_OUT, 32'(o));
    wr(dpm_pkg::OFS_DIR, 32'(d));
    sleep <= 1'b1;
    tick(2);
    wr(dpm_pkg::OFS_OUT, 32'(~o));
    wr(dpm_pkg::OFS_DIR, 32'h0);
    tick(2);
    chk("sleep_oe", d, pad_oe);
    chk("sleep_o", o & d, pad_out & d);
    v[k] = ~v[k];
    ext_val <= v;
    for (int n = 0; n < 12 && wake !== 1'b1; n++) tick(1);
    chk("wake", 1'b1, wake);
    sleep <= 1'b0;
    tick(3);
    chk("woke_oe", 11'h000, pad_oe);
    // Reset pin driven by the device and by the outside.
    int_req <= 1'b1;
    tick(2);
    chk("pin_oe", 1'b1, pin_oe);
    chk("pin_drv", 1'b0, pin_o);
    int_req <= 1'b0;
    ext_pull <= 1'b1;
    tick(6);
    chk("ext_rst", 1'b1, ext_rst);
    ext_pull <= 1'b0;
    tick(6);
    chk("ext_rel", 1'b0, ext_rst);
    // A second reset in mid-run returns every line to a pulled-up input.
    wr(dpm_pkg::OFS_DIR, 32'h7FF);
    wr(dpm_pkg::OFS_PULL, 32'h0);
    rst_i <= 1'b1;
    tick(2);
    chk("rst_oe", 11'h000, pad_oe);
    chk("rst_pu", dpm_pkg::RST_PULL, pad_pu);
    rst_i <= 1'b0;
    tick(1);
    conclude();
  end
endmodule // tb_digital_io_pin_mux

// [verilog/dpm_pin_mux.sv]
// Pin multiplexer and pad control for general purpose lines 10 to 20.
// Operation
// - Line 10: gpio, timer0 pwm, crystal out.
// - Line 11: gpio, timer1 gate, timer2 pwm.
// - Line 12: gpio, capture, antenna, word select.
// - Line 13: gpio, timer1 pwm, antenna, audio in.
// - Lines 14-15: gpio, two-wire, peripheral port.
// - Line 16: gpio or peripheral data in.
// - Line 17: gpio, cts, select, bitclock, tck.
// - Line 18: gpio, rts, irq, audio out, tms.
// - Lines 19-20: gpio, uart tx/rx, tdo/tdi.
// - Gpio lines bidirectional with disableable pull-up.
// - Enabled peripheral owns line and forces direction.
// - Pull-up independent, enabled out of reset.
// - Reset makes all lines high-impedance inputs.
// - Sleep latches and holds direction and level.
// - Enabled input lines wake device from sleep.
// - Reset pin bidirectional, driven low internally.
//
// Design decisions made here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
module dpm_pin_mux (
  input wire logic clk_i,
  input wire logic rst_i,
  // Classic Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pads of lines 10 to 20, bit 0 is line 10.
  input wire logic [10:0] pad_i,
  output logic [10:0] pad_o,
  output logic [10:0] pad_oe_o,
  output logic [10:0] pad_pu_o,
  // Peripheral side.
  input wire dpm_pkg::dpm_from_periph_s periph_i,
  output dpm_pkg::dpm_to_periph_s periph_o,
  // Power manager side.
  input wire logic sleep_i,
  output logic wake_o,
  output logic irq_o,
  // Active low reset pin and internal reset request.
  input wire logic reset_pin_low_i,
  output logic reset_pin_low_o,
  output logic reset_pin_low_oe_o,
  input wire logic int_reset_req_i,
  output logic ext_reset_o
);

  // Whole state of the block in one record.
  typedef struct packed {
    logic [10:0] dout;
    logic [10:0] dir;
    logic [10:0] pull;
    logic [11:0] pen;
    logic [10:0] ien;
    logic [10:0] stat;
    logic [10:0] mask;
    logic [10:0] s1;
    logic [10:0] s2;
    logic [10:0] s3;
    logic [10:0] filt;
    logic [2:0] rs;
    logic rfilt;
    logic [10:0] pad;
    logic [10:0] oe;
    dpm_pkg::dpm_to_periph_s pin;
    logic sleep;
    logic wake;
    logic irq;
    logic ack;
    logic [31:0] rdat;
    logic roe;
  } dpm_state_s;

  dpm_state_s s_r;
  dpm_state_s s_nxt;

  // Byte lane mask for the low 16 bits, where every field lives.
  function automatic logic [10:0] dpm_lane(input logic [3:0] sel);
    dpm_lane = {{3{sel[1]}}, {8{sel[0]}}};
  endfunction

  // Write-one-to-clear update where a new event wins over the clear.
  function automatic logic [10:0] dpm_w1c(input logic [10:0] cur, input logic [10:0] clr,
                                          input logic [10:0] set);
    dpm_w1c = (cur & ~clr) | set;
  endfunction

  // Per-line mux results and bus helpers.
  logic [10:0] own;
  logic [10:0] poe;
  logic [10:0] pout;
  logic [10:0] evt;
  logic [10:0] wm;
  logic wr;
  logic [11:0] en;
  dpm_pkg::dpm_to_periph_s tin;

  // Next-state logic for bus, mux, synchronisers and events.
  always_comb begin
    s_nxt = s_r;
    en = s_r.pen;
    own = '0;
    poe = '0;
    pout = '0;
    tin = dpm_pkg::TO_IDLE;
    // Three stage synchronisers; a change counts when stages two and three agree.
    s_nxt.s1 = pad_i;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    s_nxt.filt = s_r.filt;
    for (int i = 0; i < dpm_pkg::NL; i++) begin
      if (s_r.s2[i] == s_r.s3[i]) begin
        s_nxt.filt[i] = s_r.s2[i];
      end
    end
    s_nxt.rs = {s_r.rs[1:0], reset_pin_low_i};
    if (s_r.rs[1] == s_r.rs[2]) begin
      s_nxt.rfilt = s_r.rs[1];
    end
    if (en[dpm_pkg::PE_T0PWM]) begin
      own[0] = 1'b1;
      poe[0] = 1'b1;
      pout[0] = periph_i.timer0_pwm_out;
    end else if (en[dpm_pkg::PE_XTAL]) begin
      own[0] = 1'b1;
      poe[0] = 1'b1;
      pout[0] = periph_i.slow_crystal_out;
    end
    if (en[dpm_pkg::PE_T1GATE]) begin
      own[1] = 1'b1;
      tin.timer1_clock_gate_in = s_r.filt[1];
    end else if (en[dpm_pkg::PE_T2PWM]) begin
      own[1] = 1'b1;
      poe[1] = 1'b1;
      pout[1] = periph_i.timer2_pwm_out;
    end
    if (en[dpm_pkg::PE_T1CAP]) begin
      own[2] = 1'b1;
      tin.timer1_capture_in = s_r.filt[2];
    end else if (en[dpm_pkg::PE_ANTDIV]) begin
      own[2] = 1'b1;
      poe[2] = 1'b1;
      pout[2] = periph_i.antenna_diversity_out;
    end else if (en[dpm_pkg::PE_AUDIO]) begin
      own[2] = 1'b1;
      poe[2] = 1'b1;
      pout[2] = periph_i.audio_word_select;
    end
    if (en[dpm_pkg::PE_T1PWM]) begin
      own[3] = 1'b1;
      poe[3] = 1'b1;
      pout[3] = periph_i.timer1_pwm_out;
    end else if (en[dpm_pkg::PE_ANTDIV]) begin
      own[3] = 1'b1;
      poe[3] = 1'b1;
      pout[3] = periph_i.antenna_diversity_enable;
    end else if (en[dpm_pkg::PE_AUDIO]) begin
      own[3] = 1'b1;
      tin.audio_serial_in = s_r.filt[3];
    end
    // lines 14 and 15, two-wire pulls low only, else peripheral port.
    if (en[dpm_pkg::PE_TWOWIRE]) begin
      own[5:4] = 2'b11;
      poe[4] = periph_i.two_wire_clock_oe;
      poe[5] = periph_i.two_wire_data_oe;
      tin.two_wire_clock = s_r.filt[4];
      tin.two_wire_data = s_r.filt[5];
    end else if (en[dpm_pkg::PE_PPORT]) begin
      own[5:4] = 2'b11;
      poe[5] = 1'b1;
      pout[5] = periph_i.periph_port_data_out;
      tin.periph_port_clock_in = s_r.filt[4];
    end
    if (en[dpm_pkg::PE_PPORT]) begin
      own[6] = 1'b1;
      tin.periph_port_data_in = s_r.filt[6];
    end
    if (en[dpm_pkg::PE_JTAG]) begin
      own[7] = 1'b1;
      tin.jtag_tck = s_r.filt[7];
    end else if (en[dpm_pkg::PE_UARTB]) begin
      own[7] = 1'b1;
      tin.uart_b_clear_to_send = s_r.filt[7];
    end else if (en[dpm_pkg::PE_PPORT]) begin
      own[7] = 1'b1;
      tin.periph_port_select_in = s_r.filt[7];
    end else if (en[dpm_pkg::PE_AUDIO]) begin
      own[7] = 1'b1;
      poe[7] = 1'b1;
      pout[7] = periph_i.audio_bit_clock;
    end
    if (en[dpm_pkg::PE_JTAG]) begin
      own[8] = 1'b1;
      tin.jtag_tms = s_r.filt[8];
    end else if (en[dpm_pkg::PE_UARTB]) begin
      own[8] = 1'b1;
      poe[8] = 1'b1;
      pout[8] = periph_i.uart_b_request_to_send;
    end else if (en[dpm_pkg::PE_PPORT]) begin
      own[8] = 1'b1;
      poe[8] = 1'b1;
      pout[8] = periph_i.periph_port_irq_out;
    end else if (en[dpm_pkg::PE_AUDIO]) begin
      own[8] = 1'b1;
      poe[8] = 1'b1;
      pout[8] = periph_i.audio_serial_out;
    end
    if (en[dpm_pkg::PE_JTAG]) begin
      own[10:9] = 2'b11;
      poe[9] = 1'b1;
      pout[9] = periph_i.jtag_tdo;
      tin.jtag_tdi = s_r.filt[10];
    end else if (en[dpm_pkg::PE_UARTB]) begin
      own[10:9] = 2'b11;
      poe[9] = 1'b1;
      pout[9] = periph_i.uart_b_transmit;
      tin.uart_b_receive = s_r.filt[10];
    end
    // unowned lines follow software direction and level.
    // owned lines take the peripheral direction.
    for (int i = 0; i < dpm_pkg::NL; i++) begin
      if (!own[i]) begin
        poe[i] = s_r.dir[i];
        pout[i] = s_r.dout[i];
      end
    end
    if (!s_r.sleep) begin
      s_nxt.pad = pout;
      s_nxt.oe = poe;
    end
    s_nxt.sleep = sleep_i;
    s_nxt.pin = tin;
    // a change on an enabled input line is an event and wakes a sleeper.
    evt = (s_nxt.filt ^ s_r.filt) & s_r.ien & ~s_r.oe;
    s_nxt.wake = s_r.sleep & (|evt);
    // Bus: ack one cycle after the strobe, dropped the cycle after.
    s_nxt.ack = wb_cyc_i & wb_stb_i & ~s_r.ack;
    wr = wb_cyc_i & wb_stb_i & wb_we_i & s_r.ack;
    wm = dpm_lane(wb_sel_i);
    s_nxt.rdat = '0;
    unique case (wb_adr_i)
      dpm_pkg::OFS_OUT: s_nxt.rdat[10:0] = s_r.dout;
      dpm_pkg::OFS_DIR: s_nxt.rdat[10:0] = s_r.dir;
      dpm_pkg::OFS_PULL: s_nxt.rdat[10:0] = s_r.pull;
      dpm_pkg::OFS_IN: s_nxt.rdat[10:0] = s_r.filt;
      dpm_pkg::OFS_PEN: s_nxt.rdat[11:0] = s_r.pen;
      dpm_pkg::OFS_IEN: s_nxt.rdat[10:0] = s_r.ien;
      dpm_pkg::OFS_STAT: s_nxt.rdat[10:0] = s_r.stat;
      dpm_pkg::OFS_MASK: s_nxt.rdat[10:0] = s_r.mask;
      default: s_nxt.rdat = '0;
    endcase
    // Writes land on the edge where ack is high; unmapped writes are ignored.
    if (wr) begin
      unique case (wb_adr_i)
        dpm_pkg::OFS_OUT: s_nxt.dout = (s_r.dout & ~wm) | (wb_dat_i[10:0] & wm);
        dpm_pkg::OFS_DIR: s_nxt.dir = (s_r.dir & ~wm) | (wb_dat_i[10:0] & wm);
        // pull-up kept apart from function and direction.
        dpm_pkg::OFS_PULL: s_nxt.pull = (s_r.pull & ~wm) | (wb_dat_i[10:0] & wm);
        dpm_pkg::OFS_PEN: s_nxt.pen = (s_r.pen & ~{wb_sel_i[1], wm}) |
                                      (wb_dat_i[11:0] & {wb_sel_i[1], wm});
        dpm_pkg::OFS_IEN: s_nxt.ien = (s_r.ien & ~wm) | (wb_dat_i[10:0] & wm);
        dpm_pkg::OFS_MASK: s_nxt.mask = (s_r.mask & ~wm) | (wb_dat_i[10:0] & wm);
        default: s_nxt.dout = s_nxt.dout;
      endcase
    end
    // Sticky status: the event wins over a same-cycle clear.
    s_nxt.stat = dpm_w1c(s_r.stat,
                         (wr && wb_adr_i == dpm_pkg::OFS_STAT) ? wb_dat_i[10:0] & wm : 11'h000,
                         evt);
    s_nxt.irq = |(s_nxt.stat & s_nxt.mask);
    // the pin is pulled low while an internal reset is asked for.
    s_nxt.roe = int_reset_req_i;
  end

  // State register; reset gives inputs only, peripherals off, pull-ups on.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // every line an input with no driver.
      s_r <= '0;
      s_r.pull <= dpm_pkg::RST_PULL;
      s_r.s1 <= dpm_pkg::RST_PULL;
      s_r.s2 <= dpm_pkg::RST_PULL;
      s_r.s3 <= dpm_pkg::RST_PULL;
      s_r.filt <= dpm_pkg::RST_PULL;
      s_r.rs <= 3'h7;
      s_r.rfilt <= 1'b1;
      s_r.pin <= dpm_pkg::TO_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs come straight from the state register.
  assign wb_dat_o = s_r.rdat;
  assign wb_ack_o = s_r.ack;
  assign pad_o = s_r.pad;
  assign pad_oe_o = s_r.oe;
  assign pad_pu_o = s_r.pull;
  assign periph_o = s_r.pin;
  assign wake_o = s_r.wake;
  assign irq_o = s_r.irq;
  assign reset_pin_low_o = s_r.rdat[31] & 1'b0;
  assign reset_pin_low_oe_o = s_r.roe;
  assign ext_reset_o = ~s_r.rfilt;

  default clocking cb @(posedge clk_i); endclocking

  a_reset_hiz: assert property (rst_i |=> pad_oe_o == 11'h000)
    else $error("pad driven after reset");
  a_pullup_rst: assert property (rst_i |=> pad_pu_o == 11'h7FF)
    else $error("pull-up off after reset");
  a_gpio_dir: assert property (disable iff (rst_i)
    (!s_r.sleep && !s_r.pen[dpm_pkg::PE_PPORT]) |=> pad_oe_o[6] == $past(s_r.dir[6]))
    else $error("gpio direction wrong");
  // second uart transmit on line 19.
  a_uart_tx: assert property (disable iff (rst_i)
    (!s_r.sleep && s_r.pen[dpm_pkg::PE_UARTB] && !s_r.pen[dpm_pkg::PE_JTAG])
    |=> pad_oe_o[9] && pad_o[9] == $past(periph_i.uart_b_transmit))
    else $error("uart tx not routed");
  // debug port forces directions and wins.
  a_jtag_dir: assert property (disable iff (rst_i)
    (!s_r.sleep && s_r.pen[dpm_pkg::PE_JTAG])
    |=> !pad_oe_o[7] && !pad_oe_o[8] && pad_oe_o[9] && pad_o[9] == $past(periph_i.jtag_tdo))
    else $error("debug direction wrong");
  a_sleep_hold: assert property (disable iff (rst_i)
    s_r.sleep |=> $stable(pad_o) && $stable(pad_oe_o))
    else $error("pad changed in sleep");
  // wake only from sleep and only with an enabled input.
  a_wake_src: assert property (disable iff (rst_i)
    wake_o |-> $past(s_r.sleep) && ($past(s_r.ien) != 11'h000))
    else $error("spurious wake");
  // internal reset drives the pin low next cycle.
  a_reset_pin: assert property (disable iff (rst_i)
    int_reset_req_i |=> reset_pin_low_oe_o && !reset_pin_low_o)
    else $error("reset pin not driven");
  c_sleep_entry: cover property (disable iff (rst_i) !s_r.sleep ##1 s_r.sleep);
  c_wake: cover property (disable iff (rst_i) wake_o);
  c_uart_on: cover property (disable iff (rst_i) s_r.pen[dpm_pkg::PE_UARTB]);
endmodule // dpm_pin_mux

// [verilog/dpm_pkg.sv]
// Package for the upper digital line pin multiplexer: constants and carriers.
package dpm_pkg;
  // Number of upper digital lines handled here (lines 10 to 20).
  localparam int NL = 11;
  // Number of peripheral enable bits.
  localparam int NE = 12;
  // Register byte offsets on the bus.
  localparam logic [7:0] OFS_OUT = 8'h00;
  localparam logic [7:0] OFS_DIR = 8'h04;
  localparam logic [7:0] OFS_PULL = 8'h08;
  localparam logic [7:0] OFS_IN = 8'h0C;
  localparam logic [7:0] OFS_PEN = 8'h10;
  localparam logic [7:0] OFS_IEN = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;
  localparam logic [7:0] OFS_MASK = 8'h1C;
  // Reset values.
  localparam logic [10:0] RST_PULL = 11'h7FF;
  localparam logic [10:0] RST_ZERO = 11'h000;
  // Peripheral enable bit positions.
  localparam int PE_T0PWM = 0;
  localparam int PE_XTAL = 1;
  localparam int PE_T1GATE = 2;
  localparam int PE_T2PWM = 3;
  localparam int PE_T1CAP = 4;
  localparam int PE_T1PWM = 5;
  localparam int PE_ANTDIV = 6;
  localparam int PE_AUDIO = 7;
  localparam int PE_TWOWIRE = 8;
  localparam int PE_PPORT = 9;
  localparam int PE_UARTB = 10;
  localparam int PE_JTAG = 11;

  // Signals that peripherals drive toward the pads.
  typedef struct packed {
    logic timer0_pwm_out;
    logic slow_crystal_out;
    logic timer2_pwm_out;
    logic timer1_pwm_out;
    logic antenna_diversity_out;
    logic antenna_diversity_enable;
    logic audio_word_select;
    logic audio_bit_clock;
    logic audio_serial_out;
    logic two_wire_clock_oe;
    logic two_wire_data_oe;
    logic periph_port_data_out;
    logic periph_port_irq_out;
    logic uart_b_request_to_send;
    logic uart_b_transmit;
    logic jtag_tdo;
  } dpm_from_periph_s;

  // Signals that the pads deliver to peripherals.
  typedef struct packed {
    logic timer1_clock_gate_in;
    logic timer1_capture_in;
    logic audio_serial_in;
    logic two_wire_clock;
    logic two_wire_data;
    logic periph_port_clock_in;
    logic periph_port_data_in;
    logic periph_port_select_in;
    logic uart_b_clear_to_send;
    logic uart_b_receive;
    logic jtag_tck;
    logic jtag_tms;
    logic jtag_tdi;
  } dpm_to_periph_s;

  // Inactive values seen by peripherals that do not own their line.
  // Only the uart receive input idles high, like a serial line at rest.
  localparam dpm_to_periph_s TO_IDLE = 13'h008;
endpackage
